// ---- hw/psc_top.sv ----
// Purpose: Pitch step control: up/down and binary step selection
// Assumes: Pins synchronous-ish to clk; control style strapped static
// Notes: Analog paths are represented by enable and select levels
`timescale 1ns/10ps
module psc_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Mode and path selection
   input wire logic control_style_select,
   input wire logic passthrough_select,
   input wire logic test_in,
   // Shared control pins: up/down use or code bits
   input wire logic power_down_request, // Also step_code_bit3
   input wire logic step_up_pulse,      // Also step_code_bit2
   input wire logic step_down_pulse,    // Also step_code_bit1
   input wire logic pitch_step_clear,   // Also step_code_bit0
   // Status and controls
   output logic [4:0] pitch_step,
   output logic osc_run,
   output logic converter_out_enable,
   output logic speech_out_enable,
   output logic speech_bypass
);
   logic [4:0] step_r;
   logic [4:0] step_nxt;
   logic [4:0] por_cnt_r;
   logic por_done_r = 1'b0; // Start-up value models power application
   logic run_r;
   logic conv_en_r;
   logic speech_en_r;
   logic bypass_r;
   wire logic binary_mode;
   wire logic in_reset;
   wire logic pd_active;
   wire logic [3:0] step_code;
   wire logic step_up_bin;
   wire logic step_down_bin;
   psc_edge_if edges ();

   // The stretch counter is five bits wide; a longer stretch needs a wider counter
   if (psc_pkg::POR_CYCLES < 1 || psc_pkg::POR_CYCLES > 32) begin : g_por_fits
      $error("power-on stretch does not fit its counter");
   end

   // Pulse inputs share pins with code bits; edges only used in up/down style
   psc_edge_det u_edge (
      .clk(clk),
      .rst_b(rst_b),
      .up_raw(step_up_pulse),
      .down_raw(step_down_pulse),
      .edges(edges)
   );

   assign binary_mode = (control_style_select == 1'b1);
   assign step_code = {power_down_request, step_up_pulse, step_down_pulse, pitch_step_clear};
   assign pd_active = ~binary_mode & power_down_request;
   assign in_reset = ~rst_b | ~por_done_r;
   assign step_up_bin = edges.up_edge & ~edges.down_level;
   assign step_down_bin = edges.down_edge & ~edges.up_level;

   // Next step value; clear and coincident pulses win over single steps
   always_comb begin
      step_nxt = step_r;
      if (binary_mode) begin
         step_nxt = {1'b0, step_code};
      end else if (pd_active) begin
         step_nxt = step_r;
      end else if (pitch_step_clear) begin
         step_nxt = psc_pkg::STEP_NEUTRAL;
      end else if (edges.up_level & edges.down_level & (edges.up_edge | edges.down_edge)) begin
         step_nxt = psc_pkg::STEP_NEUTRAL;
      end else if (step_up_bin && step_r != psc_pkg::STEP_MAX) begin
         step_nxt = step_r + 5'h01;
      end else if (step_down_bin && step_r != psc_pkg::STEP_MIN) begin
         step_nxt = step_r - 5'h01;
      end
   end

   // power-on counter; a held pin is not needed
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         por_cnt_r <= 5'h00;
         por_done_r <= 1'b1;
      end else if (!por_done_r) begin
         por_cnt_r <= por_cnt_r + 5'h01;
         por_done_r <= (por_cnt_r == 5'(psc_pkg::POR_CYCLES - 1));
      end
   end

   always_ff @(posedge clk) begin
      if (in_reset) begin
         step_r <= psc_pkg::STEP_RESET;
      end else begin
         step_r <= step_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (in_reset) begin
         run_r <= 1'b0;
         conv_en_r <= 1'b0;
         speech_en_r <= 1'b0;
         bypass_r <= 1'b0;
      end else begin
         run_r <= ~pd_active;
         conv_en_r <= ~pd_active;
         speech_en_r <= ~pd_active;
         bypass_r <= passthrough_select;
      end
   end

   assign pitch_step = step_r;
   assign osc_run = run_r;
   assign converter_out_enable = conv_en_r;
   assign speech_out_enable = speech_en_r;
   assign speech_bypass = bypass_r;

   // test input unused; must stay low
   wire logic test_unused = test_in;

   // Assertions
   sequence s_up_step;
      !binary_mode && !pd_active && !pitch_step_clear && step_up_bin
         && step_r != psc_pkg::STEP_MAX;
   endsequence
   sequence s_down_step;
      !binary_mode && !pd_active && !pitch_step_clear && step_down_bin
         && step_r != psc_pkg::STEP_MIN;
   endsequence

   a_reset_step_init: assert property (@(posedge clk) !rst_b |=> pitch_step == 5'h08)
      else $error("step not initial after reset");
   a_reset_outputs_off: assert property (@(posedge clk) !rst_b |=> !osc_run
      && !speech_out_enable && !converter_out_enable)
      else $error("outputs not grounded in reset");
   a_step_up_one: assert property (@(posedge clk) disable iff (in_reset)
      s_up_step |=> pitch_step == $past(pitch_step) + 5'h01)
      else $error("step up not by one");
   a_step_down_one: assert property (@(posedge clk) disable iff (in_reset)
      s_down_step |=> pitch_step == $past(pitch_step) - 5'h01)
      else $error("step down not by one");
   a_clear_neutral: assert property (@(posedge clk) disable iff (in_reset)
      !binary_mode && !pd_active && pitch_step_clear |=> pitch_step == 5'h08)
      else $error("clear did not give neutral");
   a_binary_code: assert property (@(posedge clk) disable iff (in_reset)
      binary_mode |=> pitch_step == {1'b0, $past(step_code)})
      else $error("binary code not taken");
   a_step_range: assert property (@(posedge clk) disable iff (in_reset)
      pitch_step <= 5'h10)
      else $error("step out of range");
   a_pd_stops_osc: assert property (@(posedge clk) disable iff (in_reset)
      pd_active |=> !osc_run ##0 $stable(pitch_step))
      else $error("power-down did not stop clock");
   a_bypass_path: assert property (@(posedge clk) disable iff (in_reset)
      passthrough_select |=> speech_bypass)
      else $error("bypass not selected");
   a_convert_path: assert property (@(posedge clk) disable iff (in_reset)
      !passthrough_select |=> !speech_bypass)
      else $error("converted path not selected");

   // Coincident and held pulses; a held level must never step twice
   sequence s_both_pulses;
      !binary_mode && !pd_active && !pitch_step_clear && edges.up_level
         && edges.down_level && (edges.up_edge || edges.down_edge);
   endsequence
   sequence s_up_held;
      !binary_mode && !pitch_step_clear && edges.up_level && !edges.up_edge
         && !edges.down_edge;
   endsequence
   sequence s_down_held;
      !binary_mode && !pitch_step_clear && edges.down_level && !edges.down_edge
         && !edges.up_edge;
   endsequence

   a_both_neutral: assert property (@(posedge clk) disable iff (in_reset)
      s_both_pulses |=> pitch_step == psc_pkg::STEP_NEUTRAL)
      else $error("coincident pulses did not give neutral");
   a_sat_top: assert property (@(posedge clk) disable iff (in_reset)
      !binary_mode && !pd_active && !pitch_step_clear && step_up_bin
      && step_r == psc_pkg::STEP_MAX |=> pitch_step == psc_pkg::STEP_MAX)
      else $error("step rose past the top");
   a_sat_bottom: assert property (@(posedge clk) disable iff (in_reset)
      !binary_mode && !pd_active && !pitch_step_clear && step_down_bin
      && step_r == psc_pkg::STEP_MIN |=> pitch_step == psc_pkg::STEP_MIN)
      else $error("step fell past the bottom");
   a_up_held_once: assert property (@(posedge clk) disable iff (in_reset)
      s_up_held |=> $stable(pitch_step))
      else $error("held up pulse stepped again");
   a_down_held_once: assert property (@(posedge clk) disable iff (in_reset)
      s_down_held |=> $stable(pitch_step))
      else $error("held down pulse stepped again");
   a_init_outputs: assert property (@(posedge clk)
      in_reset |=> !osc_run && pitch_step == psc_pkg::STEP_RESET)
      else $error("outputs not initial during start-up");
endmodule

// ---- hw/psc_pkg.sv ----
// Purpose: Shared constants and types of the pitch step control block
// Assumes: 125 MHz system clock
// Notes: Step counts are those of the two control styles
package psc_pkg;
   // Step counter width and ranges
   localparam int STEP_W = 5;
   localparam logic [4:0] STEP_MIN = 5'h00;
   localparam logic [4:0] STEP_MAX = 5'h10;    // 17 steps, 0 to 16
   localparam logic [4:0] STEP_NEUTRAL = 5'h08; // No pitch change step
   localparam logic [4:0] STEP_RESET = 5'h08;
   // Power-on reset stretch, in clock cycles
   localparam int POR_CYCLES = 16;
   // Control style
   typedef enum logic {PSC_UPDOWN, PSC_BINARY} psc_style_t;
endpackage

// ---- hw/psc_edge_if.sv ----
// Purpose: Carries synchronised level and rising edges between modules
// Assumes: One clock domain
// Notes: Edges are one-cycle pulses
`timescale 1ns/10ps
interface psc_edge_if;
   logic up_edge;
   logic down_edge;
   logic up_level;
   logic down_level;
   modport src (output up_edge, output down_edge, output up_level, output down_level);
   modport dst (input up_edge, input down_edge, input up_level, input down_level);
endinterface

// ---- hw/psc_edge_det.sv ----
// Purpose: Synchronise the step pulses and find their rising edges
// Assumes: Inputs may be asynchronous to clk
// Notes: First sync stage feeds only the second stage
`timescale 1ns/10ps
module psc_edge_det (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Raw pulses
   input wire logic up_raw,
   input wire logic down_raw,
   // Synchronised result
   psc_edge_if.src edges
);
   logic [1:0] up_sync_r;
   logic [1:0] down_sync_r;
   logic up_prev_r;
   logic down_prev_r;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         up_sync_r <= 2'h0;
         down_sync_r <= 2'h0;
         up_prev_r <= 1'b0;
         down_prev_r <= 1'b0;
      end else begin
         up_sync_r <= {up_sync_r[0], up_raw};
         down_sync_r <= {down_sync_r[0], down_raw};
         up_prev_r <= up_sync_r[1];
         down_prev_r <= down_sync_r[1];
      end
   end

   assign edges.up_edge = up_sync_r[1] & ~up_prev_r;
   assign edges.down_edge = down_sync_r[1] & ~down_prev_r;
   assign edges.up_level = up_sync_r[1];
   assign edges.down_level = down_sync_r[1];
endmodule

// ---- verification/psc_pin_model.sv ----
// Purpose: Switch or host model driving the four shared pitch pins
// Assumes: Pins change only at falling clock edges
// Notes: Hold and gap are scaled far below real switch timing
`timescale 1ns/10ps
module psc_pin_model #(
   parameter int HOLD = 10,
   parameter int GAP = 6
) (
   // Clock
   input wire logic clk,
   // Shared pins
   output logic pd_or_b3,
   output logic up_or_b2,
   output logic dn_or_b1,
   output logic clr_or_b0
);
   // Released pins fall to low, as the pull-downs would pull them
   initial {pd_or_b3, up_or_b2, dn_or_b1, clr_or_b0} = 4'h0;

   task automatic pulse(input logic [3:0] lv, input logic keep);
      @(negedge clk);
      {pd_or_b3, up_or_b2, dn_or_b1, clr_or_b0} = lv;
      repeat (HOLD) @(negedge clk);
      if (!keep) begin
         {pd_or_b3, up_or_b2, dn_or_b1, clr_or_b0} = 4'h0;
         repeat (GAP) @(negedge clk);
      end
   endtask
endmodule

// ---- verification/pitch_step_control_tb_top.sv ----
// Purpose: Self-checking bench of the pitch step control block
// Assumes: Expected outputs are noted once they have settled
// Notes: Notes hold a mask and a value over all five outputs
`timescale 1ns/10ps
module pitch_step_control_tb_top;
   // Clock, controls and observed outputs
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic style = 1'b0;
   logic thru = 1'b0;
   logic pd, up, dn, clr;
   logic [4:0] pitch_step;
   logic osc_run, conv_en, spk_en, bypass;
   logic [17:0] notes[$];
   logic [17:0] n;
   logic [4:0] exp_step;
   logic [3:0] code;
   int num_errors = 0;
   int n_tests = 0;
   int i;
   int seed_val;
   event look;

   always #4 clk = ~clk;

   psc_pin_model psc_pin_model_inst (.clk(clk), .pd_or_b3(pd), .up_or_b2(up),
      .dn_or_b1(dn), .clr_or_b0(clr));

   psc_top psc_top_inst (.clk(clk), .rst_b(rst_b), .control_style_select(style),
      .passthrough_select(thru), .test_in(1'b0), .power_down_request(pd),
      .step_up_pulse(up), .step_down_pulse(dn), .pitch_step_clear(clr),
      .pitch_step(pitch_step), .osc_run(osc_run), .converter_out_enable(conv_en),
      .speech_out_enable(spk_en), .speech_bypass(bypass));

   // Record an expectation and wake the watcher
   task automatic note(input logic [8:0] m, input logic [8:0] v);
      notes.push_back({m, v});
      ->look;
   endtask

   // Masked compare; an unknown bit under the mask never passes
   always begin
      @(look);
      n = notes.pop_front();
      n_tests++;
      if ((({spk_en, conv_en, bypass, osc_run, pitch_step} ^ n[8:0]) & n[17:9]) !== 9'h000) begin
         num_errors++;
         $display("[FAIL] %0t outputs differ, expected %h", $time, n[8:0]);
      end
   end

   task automatic end_sim();
      $display("Checks %0d, errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Watchdog, well past the expected run of about 860 cycles
   initial begin
      #100000;
      num_errors++;
      end_sim();
   end

   initial begin
      seed_val = $urandom(46221);
      repeat (12) @(negedge clk);
      note(9'h1FF, 9'h008);
      rst_b = 1'b1;
      exp_step = 5'h08;
      // Two edges after release before the first pulse
      @(negedge clk);
      // Ten ups saturate at the top, eighteen downs at the bottom
      for (i = 0; i < 28; i++) begin
         thru = 1'($urandom);
         psc_pin_model_inst.pulse((i < 10) ? 4'h4 : 4'h2, 1'b0);
         if (i < 10 && exp_step != 5'h10)
            exp_step++;
         else if (i >= 10 && exp_step != 5'h00)
            exp_step--;
         note(9'h1FF, {2'b11, thru, 1'b1, exp_step});
      end
      psc_pin_model_inst.pulse(4'h6, 1'b0);
      note(9'h01F, 9'h008);
      psc_pin_model_inst.pulse(4'h4, 1'b0);
      psc_pin_model_inst.pulse(4'h1, 1'b0);
      note(9'h01F, 9'h008);
      psc_pin_model_inst.pulse(4'h8, 1'b1);
      note(9'h020, 9'h000);
      // An up pulse while powered down must be ignored
      psc_pin_model_inst.pulse(4'hC, 1'b1);
      psc_pin_model_inst.pulse(4'h8, 1'b1);
      note(9'h03F, 9'h008);
      psc_pin_model_inst.pulse(4'h0, 1'b0);
      note(9'h03F, 9'h028);
      // host reset pulse in mid-run, then the code style
      rst_b = 1'b0;
      style = 1'b1;
      repeat (2) @(negedge clk);
      note(9'h1FF, 9'h008);
      rst_b = 1'b1;
      @(negedge clk);
      for (i = 0; i < 24; i++) begin
         code = (i < 16) ? 4'(i) : 4'($urandom);
         psc_pin_model_inst.pulse(code, 1'b1);
         note(9'h1FF, {2'b11, thru, 2'b10, code});
      end
      @(negedge clk);
      end_sim();
   end
endmodule
